// file: design/gpio_port_regs.vh
// Register offsets, reset values and field masks of the six-bit port
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH
`define PIN_LEVEL_OFS        8'h00
`define OUTPUT_LATCH_OFS     8'h04
`define DIRECTION_OFS        8'h08
`define ANALOG_SELECT_OFS    8'h0C
`define PULLUP_OFS           8'h10
`define THRESHOLD_OFS        8'h14
`define SLEW_OFS             8'h18
`define OPEN_DRAIN_OFS       8'h1C
`define PORT_CONFIG_OFS      8'h20
`define DIRECTION_RESET      6'h3F
`define ANALOG_RESET         6'h37
`define IMPL_MASK            6'h37
`define PIN3_BIT             3
`define CFG_RESET_EN_BIT     0
`endif

// file: design/six_bit_io_port_control.v
// Six-bit general-purpose I/O port control with an AHB-Lite register slave
// Notes on behaviour
// R1: Writes to latch or pin-level register both update the output latch.
// R2: Latch reads return latch; pin-level reads return sampled pin levels.
// R3: Analog-select bit disables the pin's digital input buffer.
// R4: Analog pins always read zero through the pin-level register.
// R5: Analog select leaves digital output driving untouched.
// R6: Analog-select bits reset to the analog state.
// R7: Each pin's output source defaults to the latch after reset.
// R8: Enabled peripheral takes over output; pin level still readable.
// R9: Enabled analog output forces the digital driver off.
// R10: Six pins; direction one disables driver, zero drives latch value.
// R11: Pin three is input-only; its direction bit reads one.
// R12: Pin-level register writes store modified pin levels into the latch.
// R13: Direction bits still control drivers on analog-input pins.
// R14: Per-pin open-drain select: only sink when set, push-pull when clear.
// R15: Per-pin slew-limit select drives the pad slew control; the code masks off bit 3, so pin three's slew_limit stays zero.
// R16: Per-pin threshold select drives the pad input threshold control.
// R17: Per-pin weak pull-up enable bit.
// R18: Pin three pull-up on when external reset enabled or its bit set.
// R19: Two-wire serial use of a pin forces open-drain by itself.
// R20: Analog input functions connect only while analog select is set.
// R21: Pin three reads one while the external reset input is enabled.
// R22: Registers written on the clock edge, effective next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_regs.vh"
module six_bit_io_port_control #(
    parameter WIDTH = 6
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             hsel,
    input  wire [31:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output wire             hreadyout,
    output wire             hresp,
    output reg  [31:0]      hrdata,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_out,
    output reg  [WIDTH-1:0] pin_oe,
    output reg  [WIDTH-1:0] pullup_on,
    output reg  [WIDTH-1:0] slew_limit,
    output reg  [WIDTH-1:0] threshold_ttl,
    output reg  [WIDTH-1:0] analog_in_connect,
    output reg  [WIDTH-1:0] digital_in,
    input  wire [WIDTH-1:0] periph_enable,
    input  wire [WIDTH-1:0] periph_out,
    input  wire [WIDTH-1:0] periph_oe,
    input  wire [WIDTH-1:0] twi_use,
    input  wire [WIDTH-1:0] analog_out_enable
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg  [WIDTH-1:0] output_latch;
reg  [WIDTH-1:0] direction_ctrl;
reg  [WIDTH-1:0] analog_select;
reg  [WIDTH-1:0] pullup_enable;
reg  [WIDTH-1:0] input_threshold_sel;
reg  [WIDTH-1:0] slew_limit_sel;
reg  [WIDTH-1:0] open_drain_sel;
reg              external_reset_enable;
reg  [WIDTH-1:0] pin_meta;
reg  [WIDTH-1:0] pin_sync;
reg              wr_pend;
reg  [7:0]       wr_addr;
wire [WIDTH-1:0] pin_level_reg;
wire [WIDTH-1:0] mask;
wire             take;
wire [WIDTH-1:0] wd;
integer          i;

assign mask      = `IMPL_MASK;
assign hreadyout = 1'b1;
assign hresp     = 1'b0;
assign take      = hsel & hready & htrans[1];
assign wd        = hwdata[WIDTH-1:0];

// ----------------------------------------------------------------
// Pin sampling
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pin_meta <= 6'h00;
        pin_sync <= 6'h00;
    end else begin
        pin_meta <= pin_in;
        pin_sync <= pin_meta;
    end
end

// Analog pins read zero; pin three reads one under external reset
assign pin_level_reg = {pin_sync[5:4] & ~analog_select[5:4],                  // [R2] [R3] [R4]
                        pin_sync[3] | external_reset_enable,                   // [R21]
                        pin_sync[2:0] & ~analog_select[2:0]};                  // [R4] [R8]

// ----------------------------------------------------------------
// Bus slave: address phase captured, write applied in data phase
// ----------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend <= 1'b0;
        wr_addr <= 8'h00;
        hrdata  <= 32'h00000000;
    end else begin
        wr_pend <= take & hwrite;
        if (take) begin
            wr_addr <= haddr[7:0];
        end
        if (take & ~hwrite) begin
            hrdata <= 32'h00000000;
            case (haddr[7:0])
                `PIN_LEVEL_OFS:     hrdata[WIDTH-1:0] <= pin_level_reg;        // [R2]
                `OUTPUT_LATCH_OFS:  hrdata[WIDTH-1:0] <= output_latch;         // [R2]
                `DIRECTION_OFS:     hrdata[WIDTH-1:0] <= direction_ctrl | 6'h08; // [R11]
                `ANALOG_SELECT_OFS: hrdata[WIDTH-1:0] <= analog_select;
                `PULLUP_OFS:        hrdata[WIDTH-1:0] <= pullup_enable;
                `THRESHOLD_OFS:     hrdata[WIDTH-1:0] <= input_threshold_sel;
                `SLEW_OFS:          hrdata[WIDTH-1:0] <= slew_limit_sel;
                `OPEN_DRAIN_OFS:    hrdata[WIDTH-1:0] <= open_drain_sel;
                `PORT_CONFIG_OFS:   hrdata[`CFG_RESET_EN_BIT] <= external_reset_enable;
                default:            hrdata <= 32'h00000000;
            endcase
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        output_latch          <= 6'h00;
        direction_ctrl        <= `DIRECTION_RESET;
        analog_select         <= `ANALOG_RESET;                                 // [R6]
        pullup_enable         <= 6'h00;
        input_threshold_sel   <= 6'h00;
        slew_limit_sel        <= 6'h00;
        open_drain_sel        <= 6'h00;
        external_reset_enable <= 1'b1;
    end else if (wr_pend) begin                                                 // [R22]
        case (wr_addr)
            // Latch bits other than bit 3 take the written data; bit 3 is cleared by the mask
            `PIN_LEVEL_OFS:     output_latch <= wd & mask;                      // [R1] [R12]
            `OUTPUT_LATCH_OFS:  output_latch <= wd & mask;                      // [R1]
            `DIRECTION_OFS:     direction_ctrl <= (wd & mask) | 6'h08;          // [R11]
            `ANALOG_SELECT_OFS: analog_select <= wd & mask;
            `PULLUP_OFS:        pullup_enable <= wd;                            // [R17]
            `THRESHOLD_OFS:     input_threshold_sel <= wd;
            `SLEW_OFS:          slew_limit_sel <= wd & mask;
            `OPEN_DRAIN_OFS:    open_drain_sel <= wd & mask;
            `PORT_CONFIG_OFS:   external_reset_enable <= hwdata[`CFG_RESET_EN_BIT];
            default:            output_latch <= output_latch;
        endcase
    end
end

// ----------------------------------------------------------------
// Pad control
// ----------------------------------------------------------------
always @* begin
    pin_out           = 6'h00;
    pin_oe            = 6'h00;
    pullup_on         = 6'h00;
    slew_limit        = 6'h00;
    threshold_ttl     = 6'h00;
    analog_in_connect = 6'h00;
    digital_in        = 6'h00;
    for (i = 0; i < WIDTH; i = i + 1) begin
        // Latch is the default source; a peripheral replaces it
        pin_out[i] = periph_enable[i] ? periph_out[i] : output_latch[i];        // [R7] [R8]
        pin_oe[i]  = periph_enable[i] ? periph_oe[i] : ~direction_ctrl[i];      // [R10] [R13] [R5]
        if (open_drain_sel[i] | twi_use[i]) begin                              // [R14] [R19]
            pin_oe[i]  = pin_oe[i] & ~pin_out[i];
            pin_out[i] = 1'b0;
        end
        if (analog_out_enable[i] || i == `PIN3_BIT) begin                       // [R9] [R11]
            pin_oe[i] = 1'b0;
        end
        pullup_on[i]         = pullup_enable[i];                                // [R17]
        slew_limit[i]        = slew_limit_sel[i];                               // [R15]
        threshold_ttl[i]     = input_threshold_sel[i];                          // [R16]
        analog_in_connect[i] = analog_select[i];                                // [R20]
        digital_in[i]        = pin_sync[i] & ~analog_select[i];                 // [R3]
    end
    pullup_on[`PIN3_BIT] = pullup_enable[`PIN3_BIT] | external_reset_enable;    // [R18]
end

endmodule // six_bit_io_port_control
`default_nettype wire

// file: tb/six_bit_io_port_control_asserts.sv
// Port-level assertions of the six-bit port control block
`timescale 1ns/1ps
`default_nettype none
module port_chk (
    input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] hrdata,
    input wire logic [5:0]  pin_out, pin_oe, slew_limit, analog_in_connect, digital_in,
    input wire logic [5:0]  twi_use, analog_out_enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && hready && htrans[1];
    pin3_input_a: assert property (!pin_oe[3]) else $error("pin three driven");
    analog_drive_a: assert property (!(|(pin_oe & analog_out_enable)))
        else $error("driver on under analog output");
    digital_gate_a: assert property (!(|(digital_in & analog_in_connect)))
        else $error("analog pin seen as one");
    twi_drain_a: assert property (!(|(pin_oe & pin_out & twi_use)))
        else $error("two-wire pin sourcing");
    slew_write_a: assert property ($changed(slew_limit) |-> $past(take && hwrite, 2))
        else $error("slew control moved without write");
    analog_write_a: assert property ($changed(analog_in_connect) |-> $past(take && hwrite, 2))
        else $error("analog connect moved without write");
    read_hold_a: assert property ($changed(hrdata) |-> $past(take && !hwrite))
        else $error("read data moved without read");
    analog_reset_a: assert property ($rose(hresetn) |-> analog_in_connect == 6'h37)
        else $error("analog select not set after reset");
endmodule // port_chk
bind six_bit_io_port_control port_chk chk (.hclk, .hresetn, .hsel, .hwrite, .hready,
    .hreadyout, .hresp, .htrans, .hrdata, .pin_out, .pin_oe, .slew_limit,
    .analog_in_connect, .digital_in, .twi_use, .analog_out_enable);
`default_nettype wire

// file: tb/pad_model.sv
// Pad model: pin level from the block's driver, an outside source or the pull-up
`timescale 1ns/1ps
`default_nettype none
module pad_model (
    input wire logic       clk,
    input wire logic [5:0] pin_out, pin_oe, pullup_on, ext_val, ext_drive,
    output logic [5:0]     pin_in
);
    logic [5:0] noise = 6'h15;
    // A floating pin toggles so that no read of it can pass by chance
    always @(posedge clk) noise <= ~noise;
    always_comb for (int i = 0; i < 6; i++)
        pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drive[i] ? ext_val[i] :
                    pullup_on[i] ? 1'b1 : noise[i];
endmodule // pad_model
`default_nettype wire

// file: tb/test_six_bit_io_port_control.sv
// Self-checking testbench of the six-bit port control block
`timescale 1ns/1ps
`default_nettype none
module test_six_bit_io_port_control;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, r;
    logic [1:0] htrans = 0;
    logic [5:0] pe = 0, po = 0, poe = 0, twi = 0, aoe = 0, ev = 0, ed = 0;
    wire hreadyout, hresp;
    wire [31:0] hrdata;
    wire [5:0] pin_in, pin_out, pin_oe, pullup_on, slew_limit, thr, aic, din;
    int errors = 0, check_count = 0, cyc = 0;
    always #2.5 hclk = ~hclk;
    six_bit_io_port_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pin_in,
        .pin_out, .pin_oe, .pullup_on, .slew_limit, .threshold_ttl(thr),
        .analog_in_connect(aic), .digital_in(din), .periph_enable(pe), .periph_out(po),
        .periph_oe(poe), .twi_use(twi), .analog_out_enable(aoe));
    pad_model pad (.clk(hclk), .pin_out, .pin_oe, .pullup_on, .ext_val(ev),
        .ext_drive(ed), .pin_in);
    task give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge hclk) if (++cyc > 5000) begin errors++; give_verdict; end
    task chk(input [31:0] g, e);
        check_count++;
        if (g !== e) begin errors++; $display("BAD %0t got %h want %h", $time, g, e); end
    endtask
    task xfer(input [7:0] a, input w, input [31:0] d);
        @(posedge hclk);
        hsel <= 1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task settle; repeat (3) @(posedge hclk); #1; endtask
    task t_reset;
        xfer(8'h08, 0, 0); chk(r, 32'h3F);
        xfer(8'h0C, 0, 0); chk(r, 32'h37);
        settle; chk(pin_oe, 6'h00);
        chk(pullup_on, 6'h08);
        chk({hresp, hreadyout}, 2'h1);
    endtask
    task t_latch;
        xfer(8'h0C, 1, 0); xfer(8'h08, 1, 0); xfer(8'h08, 0, 0); chk(r, 32'h08);
        xfer(8'h04, 1, 32'h15); xfer(8'h04, 0, 0); chk(r, 32'h15);
        xfer(8'h00, 1, 32'h2A); xfer(8'h04, 0, 0); chk(r, 32'h22);
        settle; chk(pin_oe, 6'h37);
        chk(pin_out & pin_oe, 6'h22);
        xfer(8'h00, 0, 0); chk(r, 32'h2A);
    endtask
    task t_analog;
        xfer(8'h08, 1, 32'h02); xfer(8'h0C, 1, 32'h03);
        @(posedge hclk); ed <= 6'h02; ev <= 6'h02;
        settle; chk(pin_oe[0], 1);
        chk(aic, 6'h03);
        chk(din[1:0], 0);
        xfer(8'h00, 0, 0); chk(r[1:0], 0);
        xfer(8'h0C, 1, 0); settle; xfer(8'h00, 0, 0); chk(r[1:0], 2'h2);
        @(posedge hclk); aoe <= 6'h01; settle; chk(pin_oe[0], 0);
    endtask
    task t_drain;
        @(posedge hclk); aoe <= 0;
        xfer(8'h1C, 1, 32'h01); xfer(8'h04, 1, 32'h01); settle; chk(pin_oe[0], 0);
        xfer(8'h04, 1, 32'h04); settle;
        chk({pin_oe[0], pin_out[0], pin_oe[2]}, 3'h5);
        @(posedge hclk); twi <= 6'h04; settle; chk(pin_oe[2], 0);
    endtask
    task t_periph;
        @(posedge hclk); twi <= 0; pe <= 6'h10; poe <= 6'h10;
        xfer(8'h04, 1, 32'h10); settle; chk(pin_out[4], 0);
        xfer(8'h00, 0, 0); chk(r[4], 0);
    endtask
    task t_pads;
        xfer(8'h18, 1, 32'h3F); xfer(8'h14, 1, 32'h3F); xfer(8'h10, 1, 32'h3F);
        settle; chk({slew_limit, thr, pullup_on}, 18'h37FFF);
        xfer(8'h20, 1, 0); xfer(8'h10, 1, 32'h37); settle; chk(pullup_on, 6'h37);
        xfer(8'h40, 0, 0); chk(r, 0);
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        t_reset; t_latch; t_analog; t_drain; t_periph; t_pads;
        give_verdict;
    end
endmodule // test_six_bit_io_port_control
`default_nettype wire
